// file: tmr8_timer.v
// Top of the dual 8-bit timer/event counter with its byte register port.
// Assumes a single-cycle byte write/read port from the CPU, and a raw pin input.
`include "tmr8_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer (
  input wire clk,
  input wire nrst,
  input wire [15:0] regAddr,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata_q,
  input wire eventPin,
  input wire portPinLatch,
  output wire timerOutPin,
  output wire timerOutEn,
  output wire match0Interrupt,
  output wire match1Interrupt
);
  reg rstMeta_q;
  reg rstSync_q;
  wire rstN;
  reg pinMeta_q;
  reg pinSync_q;
  reg pinPrev_q;
  reg [7:0] port5Dir_q;
  reg [7:0] cmp0_q;
  reg [7:0] cmp0Live_q;
  reg cmp0Pend_q;
  reg cmp0Late_q;
  reg [7:0] cmp1_q;
  reg [2:0] clk0Sel_q;
  reg [2:0] clk1Sel_q;
  reg [7:0] mode0_q;
  reg [7:0] mode1_q;
  reg outFf_q;
  reg pwmActive_q;
  wire [13:0] tick;
  wire [7:0] cnt0;
  wire [7:0] cnt1;
  wire match0;
  wire match1;
  wire ovf0;
  wire tick0;
  wire tick1;
  wire run0;
  wire run1;
  wire pwm0;
  wire cmp0Wr;
  wire [7:0] cmp0Use;
  wire [7:0] cnt0Next;

  // Reset is released through two flops so every register leaves reset on one edge.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstN = rstSync_q;

  // The pin is asynchronous; edges are taken only from the second flop onward.
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      pinPrev_q <= 1'b0;
    end
    else
    begin
      pinMeta_q <= eventPin;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  tmr8_prescaler uPresc (
    .clk(clk),
    .rstN(rstN),
    .tick(tick)
  );

  // Prescaled ticks are free running, so the first tick after enable can come up to
  // one count period late.
  function sel0Tick;
    input [2:0] sel;
    input [13:0] t;
    input rise;
    input fall;
    begin
      case (sel)
        `TMR8_CS_FALL: sel0Tick = fall;
        `TMR8_CS_RISE: sel0Tick = rise;
        3'h2: sel0Tick = t[0];
        3'h3: sel0Tick = t[1];
        3'h4: sel0Tick = t[3];
        3'h5: sel0Tick = t[5];
        3'h6: sel0Tick = t[7];
        default: sel0Tick = t[12];
      endcase
    end
  endfunction

  function sel1Tick;
    input [2:0] sel;
    input [13:0] t;
    begin
      case (sel)
        3'h2: sel1Tick = t[0];
        3'h3: sel1Tick = t[4];
        3'h4: sel1Tick = t[6];
        3'h5: sel1Tick = t[9];
        3'h6: sel1Tick = t[12];
        default: sel1Tick = 1'b0;
      endcase
    end
  endfunction

  assign tick0 = sel0Tick(clk0Sel_q, tick, pinSync_q & ~pinPrev_q, ~pinSync_q & pinPrev_q);
  assign tick1 = sel1Tick(clk1Sel_q, tick);
  assign run0 = mode0_q[`TMR8_BIT_ENABLE];
  assign run1 = mode1_q[`TMR8_BIT_ENABLE];
  assign pwm0 = mode0_q[`TMR8_BIT_PWM];
  assign cmp0Use = pwm0 ? cmp0Live_q : cmp0_q;
  assign cnt0Next = cnt0 + 8'h01;

  tmr8_channel uCh0 (
    .clk(clk),
    .rstN(rstN),
    .run(run0),
    .countTick(tick0),
    .freeRun(pwm0),
    .compare(cmp0Use),
    .count_q(cnt0),
    .match(match0),
    .overflow(ovf0)
  );

  // Timer 1 never runs free; PWM mode on it is not supported.
  tmr8_channel uCh1 (
    .clk(clk),
    .rstN(rstN),
    .run(run1),
    .countTick(tick1),
    .freeRun(1'b0),
    .compare(cmp1_q),
    .count_q(cnt1),
    .match(match1),
    .overflow()
  );

  assign match0Interrupt = match0;
  assign match1Interrupt = match1;
  assign cmp0Wr = regWr && (regAddr == `TMR8_ADDR_CMP0);

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      port5Dir_q <= `TMR8_RST_PORT5_DIR;
      cmp0_q <= `TMR8_RST_ZERO;
      cmp1_q <= `TMR8_RST_ZERO;
      clk0Sel_q <= 3'h0;
      clk1Sel_q <= 3'h0;
      mode0_q <= `TMR8_RST_ZERO;
      mode1_q <= `TMR8_RST_ZERO;
    end
    else if (regWr)
    begin
      case (regAddr)
        `TMR8_ADDR_PORT5_DIR: port5Dir_q <= regWdata | 8'hE6;
        `TMR8_ADDR_CMP0: cmp0_q <= regWdata;
        `TMR8_ADDR_CMP1: cmp1_q <= regWdata;
        `TMR8_ADDR_CLK0: clk0Sel_q <= regWdata[2:0];
        `TMR8_ADDR_CLK1: clk1Sel_q <= regWdata[2:0];
        `TMR8_ADDR_MODE0: mode0_q <= regWdata & 8'hC3;
        `TMR8_ADDR_MODE1: mode1_q <= regWdata & 8'hC0;
        default: mode1_q <= mode1_q;
      endcase
    end
  end

  // PWM compare buffer: a write arms a pending update; a write after the FFH edge
  // in the same period waits one more overflow.
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cmp0Live_q <= `TMR8_RST_ZERO;
      cmp0Pend_q <= 1'b0;
      cmp0Late_q <= 1'b0;
    end
    else if (!pwm0)
    begin
      cmp0Live_q <= cmp0_q;
      cmp0Pend_q <= 1'b0;
      cmp0Late_q <= 1'b0;
    end
    else if (cmp0Wr)
    begin
      cmp0Pend_q <= 1'b1;
      cmp0Late_q <= run0 && (cnt0 == `TMR8_CNT_MAX);
    end
    else if (ovf0 && cmp0Pend_q)
    begin
      if (cmp0Late_q)
        cmp0Late_q <= 1'b0;
      else
      begin
        cmp0Live_q <= cmp0_q;
        cmp0Pend_q <= 1'b0;
      end
    end
  end

  // Output flip-flop: level bits act at write time and read back as zero.
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      outFf_q <= 1'b0;
    else if (regWr && regAddr == `TMR8_ADDR_MODE0 && !regWdata[`TMR8_BIT_PWM]
             && (regWdata[`TMR8_BIT_LVSET] ^ regWdata[`TMR8_BIT_LVCLR]))
      outFf_q <= regWdata[`TMR8_BIT_LVSET];
    else if (!pwm0 && match0 && mode0_q[`TMR8_BIT_INV])
      outFf_q <= ~outFf_q;
  end

  // The pulse ends on the tick that brings the counter to the compare value, so it spans N count clocks.
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      pwmActive_q <= 1'b0;
    else if (!run0 || !pwm0)
      pwmActive_q <= 1'b0;
    else if (ovf0)
      pwmActive_q <= (cmp0Use != 8'h00);
    else if (tick0 && (cnt0Next == cmp0Use))
      pwmActive_q <= 1'b0;
  end

  // Gating with the enable bit makes the stop take effect in the write cycle itself.
  assign timerOutPin = !mode0_q[`TMR8_BIT_OE] ? 1'b0 :
                       pwm0 ? ((pwmActive_q & run0) ^ mode0_q[`TMR8_BIT_INV]) :
                       outFf_q;
  assign timerOutEn = ~port5Dir_q[`TMR8_BIT_PIN0] & ~portPinLatch;

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      regRdata_q <= `TMR8_RST_ZERO;
    else if (regRd)
    begin
      case (regAddr)
        `TMR8_ADDR_PORT5_DIR: regRdata_q <= port5Dir_q & 8'h19;
        `TMR8_ADDR_CNT0: regRdata_q <= cnt0;
        `TMR8_ADDR_CMP0: regRdata_q <= cmp0_q;
        `TMR8_ADDR_CLK0: regRdata_q <= {5'h00, clk0Sel_q};
        `TMR8_ADDR_MODE0: regRdata_q <= mode0_q & 8'hC3;
        `TMR8_ADDR_CNT1: regRdata_q <= cnt1;
        `TMR8_ADDR_CMP1: regRdata_q <= cmp1_q;
        `TMR8_ADDR_CLK1: regRdata_q <= {5'h00, clk1Sel_q};
        `TMR8_ADDR_MODE1: regRdata_q <= mode1_q;
        default: regRdata_q <= `TMR8_RST_ZERO;
      endcase
    end
  end
endmodule // tmr8_timer
`default_nettype wire

// file: tmr8_consts.vh
// Constants for the dual 8-bit timer/event counter block.
// Assumes a 20 MHz system clock and byte-wide register access.
`ifndef TMR8_CONSTS_VH
`define TMR8_CONSTS_VH
`define TMR8_ADDR_PORT5_DIR 16'hFF25
`define TMR8_ADDR_CNT0 16'hFF20
`define TMR8_ADDR_CMP0 16'hFF21
`define TMR8_ADDR_CLK0 16'hFF22
`define TMR8_ADDR_MODE0 16'hFF2F
`define TMR8_ADDR_CNT1 16'hFF30
`define TMR8_ADDR_CMP1 16'hFF31
`define TMR8_ADDR_CLK1 16'hFF3E
`define TMR8_ADDR_MODE1 16'hFF3F
`define TMR8_RST_PORT5_DIR 8'hFF
`define TMR8_RST_ZERO 8'h00
`define TMR8_BIT_ENABLE 7
`define TMR8_BIT_PWM 6
`define TMR8_BIT_LVSET 3
`define TMR8_BIT_LVCLR 2
`define TMR8_BIT_INV 1
`define TMR8_BIT_OE 0
`define TMR8_BIT_PIN0 0
`define TMR8_CS_FALL 3'h0
`define TMR8_CS_RISE 3'h1
`define TMR8_CNT_MAX 8'hFF
`endif

// file: tmr8_prescaler.v
// Free-running prescaler giving one-cycle ticks at fixed divisions.
// Assumes it runs from the synchronised reset of the top module.
`timescale 1ns/1ps
`default_nettype none
module tmr8_prescaler (
  input wire clk,
  input wire rstN,
  output wire [13:0] tick
);
  reg [12:0] div_q;
  reg [12:0] divPrev_q;
  genvar i;
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      div_q <= 13'h0000;
      divPrev_q <= 13'h0000;
    end
    else
    begin
      div_q <= div_q + 13'h0001;
      divPrev_q <= div_q;
    end
  end
  // Bit k (0 to 12) of tick pulses once every 2^(k+1) clocks; tick[0] is every other clock, tick[13] is every clock.
  assign tick[0] = divPrev_q[0] & ~div_q[0];
  generate
    for (i = 1; i < 13; i = i + 1)
    begin : gTick
      assign tick[i] = divPrev_q[i] & ~div_q[i];
    end
  endgenerate
  assign tick[13] = 1'b1;
endmodule // tmr8_prescaler
`default_nettype wire

// file: tmr8_channel.v
// One 8-bit counter with compare match, clear and start.
// Assumes a one-cycle count strobe and a synchronised reset.
`include "tmr8_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tmr8_channel (
  input wire clk,
  input wire rstN,
  input wire run,
  input wire countTick,
  input wire freeRun,
  input wire [7:0] compare,
  output reg [7:0] count_q,
  output wire match,
  output wire overflow
);
  wire atMatch;
  assign atMatch = (count_q == compare);
  assign match = run & countTick & atMatch;
  assign overflow = run & countTick & (count_q == `TMR8_CNT_MAX);
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      count_q <= `TMR8_RST_ZERO;
    else if (!run)
      count_q <= `TMR8_RST_ZERO;
    else if (countTick)
    begin
      if (atMatch && !freeRun)
        count_q <= `TMR8_RST_ZERO;
      else
        count_q <= count_q + 8'h01;
    end
  end
endmodule // tmr8_channel
`default_nettype wire

// file: tmr8_pin_model.sv
// Far side of the shared timer pin: event pulse source and output load.
// Assumes one bench process calls its task.
`timescale 1ns/1ps
`default_nettype none
module tmr8_pin_model (
  input wire logic clk,
  input wire logic timerOutPin,
  input wire logic timerOutEn,
  output wire logic eventPin
);
  logic srcLvl = 1'b0;
  // The source yields while the timer buffer drives, so the wire never fights.
  assign eventPin = timerOutEn ? timerOutPin : srcLvl;
  task automatic level(input logic v, input int g);
    @(posedge clk);
    srcLvl <= v;
    repeat (g) @(posedge clk);
  endtask
endmodule // tmr8_pin_model
`default_nettype wire

// file: tmr8_timer_asserts.sv
// Checker for the dual 8-bit timer, bound to its top module.
// Assumes register strobes come with an idle cycle between them.
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata_q,
  input wire logic portPinLatch,
  input wire logic timerOutPin,
  input wire logic timerOutEn,
  input wire logic match0Interrupt
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire logic dirWr = regWr && regAddr == 16'hFF25;
  wire logic modeWr = regWr && regAddr == 16'hFF2F;
  latch_gate_a: assert property (portPinLatch |-> !timerOutEn)
    else $error("pin driven with latch high");
  dir_release_a: assert property (dirWr && regWdata[0] |=> !timerOutEn)
    else $error("pin driven in input mode");
  dir_drive_a: assert property (dirWr && !regWdata[0] && !portPinLatch ##1 !portPinLatch
    |-> timerOutEn) else $error("pin idle in output mode");
  dir_readback_a: assert property (dirWr ##2 regRd && regAddr == 16'hFF25
    |=> regRdata_q == ($past(regWdata, 3) & 8'h19)) else $error("direction readback wrong");
  int0_pulse_a: assert property (match0Interrupt |=> !match0Interrupt)
    else $error("match pulse too long");
  level_set_a: assert property (modeWr && !regWdata[6] && regWdata[3:2] == 2'b10 && regWdata[0]
    |=> timerOutPin) else $error("output not set high");
  pwm_stop_a: assert property (modeWr && regWdata[7:6] == 2'b01 && regWdata[0]
    |=> timerOutPin == $past(regWdata[1])) else $error("stopped pwm not inactive");
  stop_quiet_a: assert property (modeWr && !regWdata[7] |=> !match0Interrupt [*2])
    else $error("match while stopped");
  cover property (match0Interrupt && timerOutEn);
  cover property (dirWr ##2 regRd);
  cover property (modeWr && regWdata[6]);
endmodule // tmr8_timer_chk
bind tmr8_timer tmr8_timer_chk u_chk (.*);
`default_nettype wire

// file: tb_top.sv
// Bench for the dual 8-bit timer: register tasks, pin model and timing checks.
// Assumes one idle cycle between register strobes and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, nrst, regWr, regRd, portPinLatch, lastOut;
  logic [15:0] regAddr;
  logic [7:0] regWdata;
  wire logic [7:0] regRdata_q;
  wire logic eventPin, timerOutPin, timerOutEn, match0Interrupt, match1Interrupt;
  integer seed = 32'h1736b7a9;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n, m, d, t, s;
  int m0[$], m1[$], tg[$];
  tmr8_timer u_tmr8_timer (.*);
  tmr8_pin_model u_tmr8_pin_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Stamps are taken from pre-edge values, so gaps between them are exact cycle counts.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (match0Interrupt === 1'b1) m0.push_back(cyc);
    if (match1Interrupt === 1'b1) m1.push_back(cyc);
    if (timerOutPin !== lastOut) tg.push_back(cyc);
    lastOut <= timerOutPin;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, v);
    samples_checked++;
    if (v !== e)
    begin
      n_mismatch++;
      $display("ERROR %s exp %0h got %0h", nm, e, v);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk("read", e, regRdata_q);
  endtask
  task automatic waitOut(input logic v);
    int k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (timerOutPin !== v && k < 3000);
    chk("wait_out", v, timerOutPin);
    @(negedge clk);
  endtask
  initial
  begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 16'h0000;
    regWdata = 8'h00;
    portPinLatch = 1'b1;
    lastOut = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(16'hFF25, 8'h19);
    rd(16'h1234, 8'h00);
    for (t = 0; t < 2; t++)
      for (s = 2; s < 4; s++)
      begin
        n = 1 + $unsigned($random(seed)) % 15;
        d = s == 2 ? 2 : (t ? 32 : 4);
        wr(t ? 16'hFF31 : 16'hFF21, n[7:0]);
        wr(t ? 16'hFF3E : 16'hFF22, s[7:0]);
        wr(t ? 16'hFF3F : 16'hFF2F, t ? 8'hC0 : 8'h80);
        m0 = {};
        m1 = {};
        repeat (4 * (n + 1) * d) @(posedge clk);
        if (t) m0 = m1;
        chk("interval", (n + 1) * d, m0[$] - m0[$ - 1]);
        wr(t ? 16'hFF3F : 16'hFF2F, 8'h00);
        rd(t ? 16'hFF30 : 16'hFF20, 8'h00);
      end
    wr(16'hFF25, 8'hFF);
    for (s = 0; s < 2; s++)
    begin
      n = 1 + $unsigned($random(seed)) % 7;
      wr(16'hFF21, n[7:0]);
      wr(16'hFF22, s[7:0]);
      wr(16'hFF2F, 8'h80);
      m0 = {};
      repeat (n)
      begin
        u_tmr8_pin_model.level(1'b1, 6);
        u_tmr8_pin_model.level(1'b0, 6);
      end
      u_tmr8_pin_model.level(1'b1, 6);
      chk("events_rise", s, m0.size());
      u_tmr8_pin_model.level(1'b0, 6);
      chk("events_fall", 1, m0.size());
      wr(16'hFF2F, 8'h00);
    end
    portPinLatch <= 1'b0;
    wr(16'hFF25, 8'h00);
    rd(16'hFF25, 8'h00);
    chk("pin_drive", 1, timerOutEn);
    n = 1 + $unsigned($random(seed)) % 15;
    wr(16'hFF21, n[7:0]);
    wr(16'hFF22, 8'h02);
    wr(16'hFF2F, 8'h07);
    @(negedge clk);
    chk("level_low", 0, timerOutPin);
    wr(16'hFF2F, 8'h0B);
    @(negedge clk);
    chk("level_high", 1, timerOutPin);
    wr(16'hFF2F, 8'h83);
    repeat (12 * (n + 1)) @(posedge clk);
    chk("half_period", (n + 1) * 2, tg[$] - tg[$ - 1]);
    wr(16'hFF2F, 8'h03);
    wr(16'hFF2F, 8'h41);
    wr(16'hFF2F, 8'hC1);
    for (s = 0; s < 4; s++) waitOut(s[0] == 0);
    chk("pwm_width", n * 2, tg[$] - tg[$ - 1]);
    chk("pwm_period", 512, tg[$] - tg[$ - 2]);
    wr(16'hFF2F, 8'h41);
    wr(16'hFF2F, 8'h43);
    wr(16'hFF2F, 8'hC3);
    waitOut(1'b0);
    m = n + 3;
    wr(16'hFF21, m[7:0]);
    rd(16'hFF21, m[7:0]);
    waitOut(1'b1);
    chk("pwm_old", n * 2, tg[$] - tg[$ - 1]);
    waitOut(1'b0);
    waitOut(1'b1);
    chk("pwm_new", m * 2, tg[$] - tg[$ - 1]);
    waitOut(1'b0);
    wr(16'hFF2F, 8'h43);
    @(negedge clk);
    chk("pwm_stop", 1, timerOutPin);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
